// file: src/rmc_pkg.sv
// Purpose: shared constants and carrier types of the radio mode controller
// Assumes: 100 MHz system clock
// Notes: times are in nanoseconds, cycle counts derive from them
package rmc_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10; // system clock period
  localparam int PD2SB_NS = 150000; // powerdown_to_standby_time, max
  localparam int SB2ACT_NS = 130000; // standby_to_active_time
  localparam int RPD_FILT_NS = 40000; // received power filter time, min
  localparam int CE_MIN_NS = 10000; // least chip-enable pulse
  localparam int TX_MAX_NS = 4000000; // longest transmit stay
  // longest time rounds down, least time rounds up
  localparam int PD2SB_CYC = PD2SB_NS / CLK_PERIOD_NS;
  localparam int SB2ACT_CYC = (SB2ACT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RPD_FILT_CYC = (RPD_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CE_MIN_CYC = (CE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TX_MAX_CYC = TX_MAX_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 20; // width of the shared timer

  // ------------------------------------------------------------
  // fifo geometry
  // ------------------------------------------------------------
  localparam int RX_SLOTS = 3; // receive fifo slots
  localparam int SLOT_W = 2; // slot index / count width
  localparam logic [SLOT_W-1:0] SLOT_ZERO = 2'h0; // empty count

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    RMC_PWR_DOWN, RMC_PD2SB, RMC_STBY1, RMC_STBY2,
    RMC_RX_SETTLE, RMC_RX, RMC_TX_SETTLE, RMC_TX
  } rmc_state_t;

  // controller-side control bits
  typedef struct packed {
    logic power_up_bit; // power up
    logic primary_receive_select; // receive role
    logic chip_enable; // radio chip-enable
  } rmc_ctrl_t;

  // received packet report from the baseband
  typedef struct packed {
    logic valid; // packet ended
    logic addr_match; // address matched
    logic crc_ok; // crc good
  } rmc_rxpkt_t;

endpackage

// file: src/rmc_mode_ctrl.sv
// Purpose: operating mode state machine of the radio transceiver
// Assumes: control bits and baseband events arrive on i_clock
// Notes: the register map itself lives behind the serial link
`timescale 1ns/1ns
`default_nettype none
module rmc_mode_ctrl (
  input wire logic i_clock, // system clock
  input wire logic i_reset, // sync reset, high
  input wire rmc_pkg::rmc_ctrl_t i_ctrl, // control bits
  input wire logic i_tx_fifo_empty, // transmit fifo empty
  input wire logic i_tx_loaded, // packet written to tx fifo
  input wire logic i_tx_done, // packet sent on air
  input wire rmc_pkg::rmc_rxpkt_t i_rx_pkt, // receive packet report
  input wire logic i_rx_read, // controller pops rx slot
  input wire logic i_power_raw, // raw in-channel power above threshold
  output var rmc_pkg::rmc_state_t o_state, // current mode
  output logic o_radio_on, // radio enabled
  output logic o_synth_on, // synthesizer running
  output logic o_rx_store, // store payload pulse
  output logic o_rx_drop, // discard payload pulse
  output logic [rmc_pkg::SLOT_W-1:0] o_rx_count, // rx slots used
  output logic o_received_power_flag, // filtered power flag
  output logic o_tx_overtime // transmit exceeded limit
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  rmc_pkg::rmc_state_t state_reg, state_next; // mode register
  logic [rmc_pkg::TMR_W-1:0] tmr_reg; // settle / start-up timer
  logic [rmc_pkg::TMR_W-1:0] ce_cnt_reg; // chip-enable high time
  logic [rmc_pkg::TMR_W-1:0] tx_cnt_reg; // time spent transmitting
  logic [rmc_pkg::TMR_W-1:0] rpd_cnt_reg; // power persistence
  logic [rmc_pkg::SLOT_W-1:0] rx_cnt_reg; // rx fifo occupancy
  logic rpd_reg; // filtered flag
  logic ovt_reg; // overtime flag
  logic pwr_s1_reg, pwr_s2_reg; // power input synchroniser
  logic ce_long; // enable held past least pulse
  logic tmr_done; // timer expired
  logic pkt_ok; // good packet arrived
  logic rx_full; // no vacant slot

  // cycles of the current timed state
  function automatic logic [rmc_pkg::TMR_W-1:0] wait_of(input rmc_pkg::rmc_state_t s);
    if (s == rmc_pkg::RMC_PD2SB) begin
      return rmc_pkg::TMR_W'(rmc_pkg::PD2SB_CYC);
    end
    return rmc_pkg::TMR_W'(rmc_pkg::SB2ACT_CYC);
  endfunction

  assign tmr_done = (tmr_reg == rmc_pkg::TMR_W'(1));
  assign ce_long = (ce_cnt_reg >= rmc_pkg::TMR_W'(rmc_pkg::CE_MIN_CYC));
  assign pkt_ok = i_rx_pkt.valid && i_rx_pkt.addr_match && i_rx_pkt.crc_ok;
  assign rx_full = (rx_cnt_reg == rmc_pkg::SLOT_W'(rmc_pkg::RX_SLOTS));

  // ------------------------------------------------------------
  // next mode
  // ------------------------------------------------------------
  // registers stay outside this block, so every mode keeps them
  // map always reachable
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      rmc_pkg::RMC_PWR_DOWN: begin
        if (i_ctrl.power_up_bit) begin
          state_next = rmc_pkg::RMC_PD2SB;
        end
      end
      rmc_pkg::RMC_PD2SB: begin
        if (tmr_done) begin
          state_next = rmc_pkg::RMC_STBY1;
        end
      end
      rmc_pkg::RMC_STBY1: begin
        if (i_ctrl.chip_enable && i_ctrl.primary_receive_select) begin
          state_next = rmc_pkg::RMC_RX_SETTLE;
        end else if (ce_long && !i_ctrl.primary_receive_select && !i_tx_fifo_empty) begin
          state_next = rmc_pkg::RMC_TX_SETTLE;
        end
      end
      rmc_pkg::RMC_STBY2: begin
        if (!i_ctrl.chip_enable) begin
          state_next = rmc_pkg::RMC_STBY1;
        end else if (i_tx_loaded || !i_tx_fifo_empty) begin
          state_next = rmc_pkg::RMC_TX_SETTLE;
        end
      end
      rmc_pkg::RMC_RX_SETTLE, rmc_pkg::RMC_TX_SETTLE: begin
        if (!i_ctrl.chip_enable && state_reg == rmc_pkg::RMC_RX_SETTLE) begin
          state_next = rmc_pkg::RMC_STBY1;
        end else if (tmr_done) begin
          state_next = (state_reg == rmc_pkg::RMC_RX_SETTLE) ? rmc_pkg::RMC_RX
                                                              : rmc_pkg::RMC_TX;
        end
      end
      rmc_pkg::RMC_RX: begin
        if (!i_ctrl.chip_enable) begin
          state_next = rmc_pkg::RMC_STBY1;
        end else if (!i_ctrl.primary_receive_select) begin
          // direct role swap pays the settle time again
          state_next = rmc_pkg::RMC_TX_SETTLE;
        end
      end
      rmc_pkg::RMC_TX: begin
        if (i_tx_done) begin
          if (!i_ctrl.chip_enable) begin
            state_next = rmc_pkg::RMC_STBY1;
          end else if (i_ctrl.primary_receive_select) begin
            state_next = rmc_pkg::RMC_RX_SETTLE;
          end else if (!i_tx_fifo_empty) begin
            state_next = rmc_pkg::RMC_TX;
          end else begin
            state_next = rmc_pkg::RMC_STBY2;
          end
        end
      end
    endcase
    if (!i_ctrl.power_up_bit) begin
      state_next = rmc_pkg::RMC_PWR_DOWN;
    end
  end

  // ------------------------------------------------------------
  // mode register
  // ------------------------------------------------------------
  // reset into power down
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_reg <= rmc_pkg::RMC_PWR_DOWN;
    end else begin
      state_reg <= state_next;
    end
  end

  // settle timer, reloaded on entry to a timed state
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      tmr_reg <= '0;
    end else if (state_next != state_reg || (state_reg == rmc_pkg::RMC_TX && i_tx_done)) begin
      tmr_reg <= wait_of(state_next);
    end else if (tmr_reg != '0) begin
      tmr_reg <= tmr_reg - rmc_pkg::TMR_W'(1);
    end
  end

  // chip-enable high time, saturating
  always_ff @(posedge i_clock) begin
    if (i_reset || !i_ctrl.chip_enable) begin
      ce_cnt_reg <= '0;
    end else if (!ce_long) begin
      ce_cnt_reg <= ce_cnt_reg + rmc_pkg::TMR_W'(1);
    end
  end

  // ------------------------------------------------------------
  // transmit time guard
  // ------------------------------------------------------------
  // flag overlong transmit
  // the controller owns the limit in manual use; we only report it
  always_ff @(posedge i_clock) begin
    if (i_reset || state_reg != rmc_pkg::RMC_TX || i_tx_done) begin
      tx_cnt_reg <= '0;
    end else if (tx_cnt_reg != rmc_pkg::TMR_W'(rmc_pkg::TX_MAX_CYC)) begin
      tx_cnt_reg <= tx_cnt_reg + rmc_pkg::TMR_W'(1);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ovt_reg <= 1'b0;
    end else begin
      ovt_reg <= (tx_cnt_reg == rmc_pkg::TMR_W'(rmc_pkg::TX_MAX_CYC));
    end
  end

  // ------------------------------------------------------------
  // receive fifo occupancy
  // ------------------------------------------------------------
  // store good packets
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rx_cnt_reg <= rmc_pkg::SLOT_ZERO;
    end else begin
      unique case ({state_reg == rmc_pkg::RMC_RX && pkt_ok && !rx_full,
                    i_rx_read && rx_cnt_reg != rmc_pkg::SLOT_ZERO})
        2'b10: rx_cnt_reg <= rx_cnt_reg + rmc_pkg::SLOT_W'(1);
        2'b01: rx_cnt_reg <= rx_cnt_reg - rmc_pkg::SLOT_W'(1);
        default: rx_cnt_reg <= rx_cnt_reg;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_rx_store <= 1'b0;
      o_rx_drop <= 1'b0;
    end else begin
      o_rx_store <= state_reg == rmc_pkg::RMC_RX && pkt_ok && !rx_full;
      o_rx_drop <= state_reg == rmc_pkg::RMC_RX && pkt_ok && rx_full;
    end
  end

  // ------------------------------------------------------------
  // received power filter
  // ------------------------------------------------------------
  // raw detector is analog-side, so synchronise first
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      pwr_s1_reg <= 1'b0;
      pwr_s2_reg <= 1'b0;
    end else begin
      pwr_s1_reg <= i_power_raw;
      pwr_s2_reg <= pwr_s1_reg;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset || state_reg != rmc_pkg::RMC_RX || !pwr_s2_reg) begin
      rpd_cnt_reg <= '0;
    end else if (rpd_cnt_reg != rmc_pkg::TMR_W'(rmc_pkg::RPD_FILT_CYC)) begin
      rpd_cnt_reg <= rpd_cnt_reg + rmc_pkg::TMR_W'(1);
    end
  end

  // flag is latched outside receive so the last reading survives
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rpd_reg <= 1'b0;
    end else if (state_reg == rmc_pkg::RMC_RX) begin
      rpd_reg <= (rpd_cnt_reg == rmc_pkg::TMR_W'(rmc_pkg::RPD_FILT_CYC));
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // radio off in power down
  assign o_state = state_reg;
  assign o_radio_on = (state_reg != rmc_pkg::RMC_PWR_DOWN);
  assign o_synth_on = (state_reg == rmc_pkg::RMC_RX_SETTLE) || (state_reg == rmc_pkg::RMC_RX)
                   || (state_reg == rmc_pkg::RMC_TX_SETTLE) || (state_reg == rmc_pkg::RMC_TX);
  assign o_rx_count = rx_cnt_reg;
  assign o_received_power_flag = rpd_reg;
  assign o_tx_overtime = ovt_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence pd_start_s;
    state_reg == rmc_pkg::RMC_PWR_DOWN && i_ctrl.power_up_bit;
  endsequence

  reset_pd_a: assert property (
    @(posedge i_clock) i_reset |=> state_reg == rmc_pkg::RMC_PWR_DOWN)
    else $error("reset did not give power down");
  pwr_low_a: assert property (@(posedge i_clock) disable iff (i_reset)
    !i_ctrl.power_up_bit |=> state_reg == rmc_pkg::RMC_PWR_DOWN)
    else $error("power-up low did not reach power down");
  pu_standby_a: assert property (@(posedge i_clock) disable iff (i_reset)
    pd_start_s |=> state_reg == rmc_pkg::RMC_PD2SB)
    else $error("power-up did not start standby entry");
  ce_drop_a: assert property (@(posedge i_clock) disable iff (i_reset)
    state_reg == rmc_pkg::RMC_RX && !i_ctrl.chip_enable && i_ctrl.power_up_bit
    |=> state_reg == rmc_pkg::RMC_STBY1)
    else $error("enable low did not leave receive");
  stby2_go_a: assert property (@(posedge i_clock) disable iff (i_reset)
    state_reg == rmc_pkg::RMC_STBY2 && i_tx_loaded && i_ctrl.chip_enable && i_ctrl.power_up_bit
    |=> o_synth_on)
    else $error("standby-II load did not start synthesizer");
  // a pop in the same cycle legally moves the count, so it is left out
  full_drop_a: assert property (@(posedge i_clock) disable iff (i_reset)
    state_reg == rmc_pkg::RMC_RX && pkt_ok && rx_full && !i_rx_read
    |=> o_rx_drop && $stable(rx_cnt_reg))
    else $error("full fifo stored a packet");
  rpd_quiet_a: assert property (@(posedge i_clock) disable iff (i_reset)
    state_reg == rmc_pkg::RMC_RX && $rose(pwr_s2_reg) |=> !rpd_reg [*8])
    else $error("power flag set too early");
  tx_hold_a: assert property (@(posedge i_clock) disable iff (i_reset)
    state_reg == rmc_pkg::RMC_TX && !i_tx_done && i_ctrl.power_up_bit
    && !i_ctrl.primary_receive_select |=> state_reg == rmc_pkg::RMC_TX)
    else $error("left transmit before packet sent");
  tx_empty_a: assert property (@(posedge i_clock) disable iff (i_reset)
    state_reg == rmc_pkg::RMC_TX && i_tx_done && i_ctrl.chip_enable && i_ctrl.power_up_bit
    && !i_ctrl.primary_receive_select && i_tx_fifo_empty |=> state_reg == rmc_pkg::RMC_STBY2)
    else $error("empty fifo did not enter standby-II");
  settle_a: assert property (@(posedge i_clock) disable iff (i_reset)
    $rose(state_reg == rmc_pkg::RMC_TX_SETTLE) |-> state_reg != rmc_pkg::RMC_TX [*8])
    else $error("transmit reached without settling");

endmodule
`default_nettype wire

// file: tb/rmc_air_model.sv
// Purpose: far side of the mode controller, air timing and raw power
// Assumes: link clock unrelated in phase to i_clock
// Notes: raw power moves only on link clock edges
`timescale 1ns/1ns
`default_nettype none
module rmc_air_model (
  input wire logic i_clock, // system clock
  input wire logic i_reset, // sync reset, high
  input wire logic i_link_clk, // air side clock
  input wire logic i_power_req, // bench wants power present
  input wire logic i_send, // start one packet on air
  input wire logic [15:0] i_send_len, // air time in cycles
  output logic o_power_raw, // raw power above threshold
  output logic o_tx_done // packet sent pulse
);
  logic [15:0] air_reg; // remaining air time
  // ----------
  // raw power, async to the system clock
  // ----------
  always_ff @(posedge i_link_clk) begin
    o_power_raw <= i_power_req & ~i_reset;
  end
  // ----------
  // air time of one packet
  // ----------
  // air time bounded
  // short lengths keep transmit far under the limit
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      air_reg <= 16'h0000;
      o_tx_done <= 1'b0;
    end else begin
      o_tx_done <= (air_reg == 16'h0001);
      if (i_send) begin
        air_reg <= i_send_len;
      end else if (air_reg != 16'h0000) begin
        air_reg <= air_reg - 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/tb_radio_mode_controller.sv
// Purpose: self-checking bench for the radio mode controller
// Assumes: timer figures taken from the package constants
// Notes: the 4 ms guard is not reached, the run would be too long
`timescale 1ns/1ns
`default_nettype none
module tb_radio_mode_controller;
  // ----------
  // stimulus and observed signals
  // ----------
  logic i_clock = 1'b0; // system clock
  logic i_reset = 1'b1; // sync reset
  logic link_clk = 1'b0; // air side clock
  rmc_pkg::rmc_ctrl_t ctrl = '0; // control bits
  logic fifo_empty = 1'b1; // tx fifo empty
  logic tx_loaded = 1'b0; // load pulse
  rmc_pkg::rmc_rxpkt_t pkt = '0; // packet report
  logic rx_read = 1'b0; // pop pulse
  logic power_req = 1'b0; // ask model for power
  logic send = 1'b0; // start air time
  logic [15:0] send_len = 16'h0010; // air time
  logic power_raw, tx_done, radio_on, synth_on, rx_store, rx_drop, flag;
  logic overtime; // transmit overtime flag
  logic [rmc_pkg::SLOT_W-1:0] rx_count; // slots used
  rmc_pkg::rmc_state_t state; // current mode
  int n_fail = 0;
  int n_tests = 0;
  int cnt; // cycles spent in a wait
  int exp_count; // expected slots used
  initial begin
    forever #5 i_clock = ~i_clock;
  end
  // 125 ns link clock, phase unrelated to i_clock
  initial begin
    #7;
    forever begin
      #63 link_clk = ~link_clk;
      #62 link_clk = ~link_clk;
    end
  end
  rmc_mode_ctrl DUT (.i_clock(i_clock), .i_reset(i_reset), .i_ctrl(ctrl),
    .i_tx_fifo_empty(fifo_empty), .i_tx_loaded(tx_loaded), .i_tx_done(tx_done),
    .i_rx_pkt(pkt), .i_rx_read(rx_read), .i_power_raw(power_raw), .o_state(state),
    .o_radio_on(radio_on), .o_synth_on(synth_on), .o_rx_store(rx_store),
    .o_rx_drop(rx_drop), .o_rx_count(rx_count), .o_received_power_flag(flag),
    .o_tx_overtime(overtime));
  rmc_air_model air (.i_clock(i_clock), .i_reset(i_reset), .i_link_clk(link_clk),
    .i_power_req(power_req), .i_send(send), .i_send_len(send_len),
    .o_power_raw(power_raw), .o_tx_done(tx_done));
  // ----------
  // shared tasks
  // ----------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // inputs move 1 ns after the edge, outputs are settled there too
  task automatic step(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  // bounded wait for a mode, a timeout ends the run
  task automatic wait_state(input rmc_pkg::rmc_state_t s, input int lim);
    cnt = 0;
    while (state !== s && cnt < lim) begin
      step(1);
      cnt++;
    end
    if (state !== s) begin
      chk("wait timeout", 16'h0001, 16'h0000);
      complete_run();
    end
  endtask
  // expected {store, drop} of one packet report against slots used
  function automatic logic [1:0] rx_exp(input logic good, input int used);
    return {good && used < rmc_pkg::RX_SLOTS, good && used == rmc_pkg::RX_SLOTS};
  endfunction
  // one receive op, report or pop; count follows the fifo rules
  task automatic rx_op(input logic pop, input logic am, input logic ok, input logic in_rx);
    logic [1:0] ex;
    ex = rx_exp(!pop && am && ok && in_rx, exp_count);
    if (pop) begin
      rx_read = 1'b1;
    end else begin
      pkt = '{valid: 1'b1, addr_match: am, crc_ok: ok};
    end
    step(1);
    chk("store", rx_store, ex[1]);
    chk("drop", rx_drop, ex[0]);
    if (pop && exp_count > 0) begin
      exp_count--;
    end else if (ex[1]) begin
      exp_count++;
    end
    chk("count", rx_count, exp_count[1:0]);
    // an idle edge between ops so two pulses never merge
    rx_read = 1'b0;
    pkt = '0;
    step(1);
  endtask
  // random air time of one packet
  task automatic tx_air();
    send_len = 16'(8 + $urandom_range(24));
    send = 1'b1;
    step(1);
    send = 1'b0;
  endtask
  // ----------
  // main sequence
  // ----------
  initial begin
    void'($urandom(32'h9e74));
    exp_count = 0;
    step(16);
    i_reset = 1'b0;
    chk("state", state, rmc_pkg::RMC_PWR_DOWN);
    chk("radio", radio_on, 1'b0);
    rx_op(1'b0, 1'b1, 1'b1, 1'b0);
    ctrl.power_up_bit = 1'b1;
    step(1);
    chk("state", state, rmc_pkg::RMC_PD2SB);
    wait_state(rmc_pkg::RMC_STBY1, 15010);
    chk("pd2sb", cnt >= rmc_pkg::PD2SB_CYC - 10 && cnt <= rmc_pkg::PD2SB_CYC, 1'b1);
    chk("radio", {radio_on, synth_on}, 2'h2);
    ctrl = '{power_up_bit: 1'b1, primary_receive_select: 1'b1, chip_enable: 1'b1};
    step(1);
    chk("state", state, rmc_pkg::RMC_RX_SETTLE);
    wait_state(rmc_pkg::RMC_RX, 13010);
    chk("settle", cnt >= rmc_pkg::SB2ACT_CYC - 2 && cnt <= rmc_pkg::SB2ACT_CYC + 2, 1'b1);
    // fill to overflow first, then random traffic with pops
    for (int k = 0; k < 40; k++) begin
      rx_op(k > 4 && $urandom_range(3) == 0, k < 5 || $urandom_range(1),
        k < 5 || $urandom_range(1), 1'b1);
    end
    chk("state", state, rmc_pkg::RMC_RX);
    // short burst of power must be filtered out
    power_req = 1'b1;
    step(2000);
    power_req = 1'b0;
    step(2100);
    chk("flag short", flag, 1'b0);
    power_req = 1'b1;
    step(3900);
    chk("flag early", flag, 1'b0);
    step(200);
    chk("flag", flag, 1'b1);
    power_req = 1'b0;
    ctrl.chip_enable = 1'b0;
    step(1);
    chk("state", state, rmc_pkg::RMC_STBY1);
    chk("flag hold", flag, 1'b1);
    fifo_empty = 1'b0;
    // nothing else driven until enable settles
    ctrl = '{power_up_bit: 1'b1, primary_receive_select: 1'b0, chip_enable: 1'b1};
    wait_state(rmc_pkg::RMC_TX_SETTLE, 1100);
    chk("ce pulse", cnt >= rmc_pkg::CE_MIN_CYC - 1, 1'b1);
    wait_state(rmc_pkg::RMC_TX, 13010);
    chk("synth", synth_on, 1'b1);
    ctrl.chip_enable = 1'b0;
    step(3);
    chk("state", state, rmc_pkg::RMC_TX);
    tx_air();
    wait_state(rmc_pkg::RMC_STBY1, 40);
    ctrl.chip_enable = 1'b1;
    wait_state(rmc_pkg::RMC_TX, 14200);
    tx_air();
    step(60);
    chk("state", state, rmc_pkg::RMC_TX);
    fifo_empty = 1'b1;
    tx_air();
    step(60);
    chk("state", state, rmc_pkg::RMC_STBY2);
    tx_loaded = 1'b1;
    fifo_empty = 1'b0;
    step(1);
    tx_loaded = 1'b0;
    chk("state", state, rmc_pkg::RMC_TX_SETTLE);
    chk("synth", synth_on, 1'b1);
    // direct swap from transmit to receive pays the settle again
    wait_state(rmc_pkg::RMC_TX, 13010);
    ctrl.primary_receive_select = 1'b1;
    tx_air();
    step(60);
    chk("state", state, rmc_pkg::RMC_RX_SETTLE);
    chk("overtime", overtime, 1'b0);
    // power-up low in mid-settle aborts at once
    ctrl.power_up_bit = 1'b0;
    step(1);
    chk("state", state, rmc_pkg::RMC_PWR_DOWN);
    chk("radio", {radio_on, synth_on}, 2'h0);
    chk("count", rx_count, exp_count[1:0]);
    complete_run();
  end
endmodule
`default_nettype wire
